// File: reset_source_combiner.sv
// reset source combiner with cause flags behind an AHB-Lite slave
// Notes on behaviour
// - Nine reset requests are taken: power-on, pin, instruction, watchdog, brown-out, config mismatch, trap, illegal opcode, uninitialised W.
// - All requests merge into one master reset output for core and peripherals.
// - Any single active request asserts the master reset, with no priority or masking.
// - While the master reset is active the designated registers are forced to their reset values.
// - Undesignated registers keep their contents over every reset but power-on, which clears irqStatus, presets the flags and leaves retained undefined.
// - Each reset type sets its own flag in reset_control_status.
// - Power-on clears every cause flag except brown-out and power-on in bits 1:0, which it sets.
// - Software may set or clear any cause flag by writing it, but a write cannot clear a flag whose request is active in the same cycle.
// - A software write to a cause flag only changes the flag and never asserts the master reset.
`timescale 1ns/1ps
`default_nettype none

module reset_source_combiner
	import reset_source_pkg::*;
#(
	parameter int CAUSES = reset_source_pkg::NUM_CAUSES
)
(
	// clock and power-on reset
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	// reset requests
	input  wire reset_source_pkg::reset_req_t resetReq,
	// AHB-Lite slave
	input  wire reset_source_pkg::ahb_req_t   ahbIn,
	output var  logic                        hreadyout,
	output var  logic                        hresp,
	output var  logic [31:0]                 hrdata,
	// to core and peripherals
	output var  logic                        master_reset,
	output wire logic [8:0]                  resetCause,
	// interrupt
	output var  logic                        irq
);
	import reset_source_pkg::*;

	generate
		if (CAUSES != NUM_CAUSES)
		begin : g_bad_causes
			$error("reset_source_combiner serves exactly nine causes");
		end
	endgenerate

	logic        rstSyncN;
	logic [8:0]  reqVec;
	logic [8:0]  reqPrev;
	logic [8:0]  irqStatus;
	logic [8:0]  irqMask;
	logic [31:0] retained;
	logic        addrPhase;
	logic        dpWrite;
	logic [7:0]  dpAddr;
	logic        wrFlags;
	logic        wrIrqStatus;
	logic        wrIrqMask;
	logic        wrRetained;
	logic [31:0] next_hrdata;

	reset_release u_release
	(
		.mclk     (mclk),
		.rst_n    (rst_n),
		.rstSyncN (rstSyncN)
	);

	// nine request vector
	// power-on is the reset input itself, seen through the flag reset value
	assign reqVec = {resetReq, 1'b0};

	// bus decode
	assign addrPhase   = ahbIn.hsel & ahbIn.htrans[HTRANS_ACTIVE_BIT] & ahbIn.hready;
	assign wrFlags     = dpWrite & (dpAddr == OFS_RESET_CONTROL_STATUS);
	assign wrIrqStatus = dpWrite & (dpAddr == OFS_IRQ_STATUS);
	assign wrIrqMask   = dpWrite & (dpAddr == OFS_IRQ_MASK);
	assign wrRetained  = dpWrite & (dpAddr == OFS_RETAINED);

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			dpWrite <= 1'b0;
			dpAddr  <= 8'h00;
		end
		else
		begin
			dpWrite <= addrPhase & ahbIn.hwrite;
			dpAddr  <= ahbIn.haddr[7:0];
		end
	end

	// merged master reset
	// a plain OR: no source can hold off or outrank another
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			master_reset <= 1'b1;
		else
			master_reset <= |reqVec;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CAUSES; gi++)
		begin : g_flag
			cause_flag_cell #(
				.POR_VAL (CAUSE_POR_VAL[gi])
			) u_cell (
				.mclk  (mclk),
				.rstN  (rstSyncN),
				.hwSet (reqVec[gi]),
				.wrEn  (wrFlags),
				.wrVal (ahbIn.hwdata[gi]),
				.flag  (resetCause[gi])
			);
		end
	endgenerate

	// request edges raise sticky interrupt bits; set wins over clear
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			reqPrev   <= 9'h000;
			irqStatus <= 9'h000;
		end
		else
		begin
			reqPrev   <= reqVec;
			irqStatus <= (irqStatus & ~({9{wrIrqStatus}} & ahbIn.hwdata[8:0]))
				| (reqVec & ~reqPrev);
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			irqMask <= IRQ_MASK_RST;
		else if (master_reset)
			irqMask <= IRQ_MASK_RST;
		else if (wrIrqMask)
			irqMask <= ahbIn.hwdata[8:0];
	end

	// retained word has no reset at all
	always_ff @(posedge mclk)
	begin
		if (wrRetained)
			retained <= ahbIn.hwdata;
	end

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			irq <= 1'b0;
		else
			irq <= |(irqStatus & irqMask);
	end

	// read data registered at the address phase; unmapped reads zero
	always_comb
	begin
		next_hrdata = 32'h0000_0000;
		unique case (ahbIn.haddr[7:0])
			OFS_RESET_CONTROL_STATUS: next_hrdata[8:0] = resetCause;
			OFS_IRQ_STATUS:           next_hrdata[8:0] = irqStatus;
			OFS_IRQ_MASK:             next_hrdata[8:0] = irqMask;
			OFS_RETAINED:             next_hrdata      = retained;
			OFS_LIVE_STATUS:          next_hrdata[LIVE_MASTER_BIT:0] = {master_reset, reqVec};
			default:                  next_hrdata      = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			if (addrPhase & ~ahbIn.hwrite)
				hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstSyncN);

	a_any_source: assert property (|reqVec |=> master_reset)
		else $error("request did not assert master reset");
	// the edge that lifts the internal reset still leaves master_reset high
	a_quiet_release: assert property (rstSyncN && reqVec == 9'h000 |=> !master_reset)
		else $error("master reset without a request");
	a_cause_sets: assert property (reqVec != 9'h000 |=> (resetCause & $past(reqVec)) == $past(reqVec))
		else $error("cause flag not set by its request");
	a_por_value: assert property ($rose(rstSyncN) |-> resetCause == CAUSE_POR_VAL)
		else $error("power-on flag value wrong");
	a_sw_writes: assert property (wrFlags && reqVec == 9'h000 |=> resetCause == $past(ahbIn.hwdata[8:0]))
		else $error("software flag write lost");
	a_sw_no_reset: assert property (wrFlags && reqVec == 9'h000 |=> !master_reset ##1 !master_reset || |$past(reqVec))
		else $error("flag write caused master reset");
	a_mask_forced: assert property (master_reset |=> irqMask == IRQ_MASK_RST)
		else $error("mask not forced during master reset");
	a_retain_word: assert property (master_reset && !wrRetained |=> $stable(retained))
		else $error("retained word changed by reset");
	a_flags_survive: assert property (master_reset && !wrFlags |=> (resetCause & $past(resetCause)) == $past(resetCause))
		else $error("master reset cleared a cause flag");
	a_irq_follow: assert property (1'b1 |=> irq == |($past(irqStatus) & $past(irqMask)))
		else $error("interrupt output does not follow status and mask");

	c_watchdog_reset: cover property (resetReq.watchdog_timeout_reset ##1 master_reset ##[1:8] !master_reset);
	c_flag_clear: cover property (wrFlags && ahbIn.hwdata[8:0] == 9'h000);
	c_irq_raise: cover property ($rose(irq));
	c_set_vs_clear: cover property (wrFlags && reqVec != 9'h000 && (ahbIn.hwdata[8:0] & reqVec) == 9'h000);

endmodule

`default_nettype wire

// File: reset_source_pkg.sv
// shared constants and carrier types for the reset source combiner
package reset_source_pkg;

	// number of reset causes, including power-on
	localparam int NUM_CAUSES = 9;

	// cause bit positions inside reset_control_status
	localparam int CAUSE_POWER_ON  = 0;
	localparam int CAUSE_BROWN_OUT = 1;
	localparam int CAUSE_EXT_PIN   = 2;
	localparam int CAUSE_SW_INSTR  = 3;
	localparam int CAUSE_WATCHDOG  = 4;
	localparam int CAUSE_CFG_MISM  = 5;
	localparam int CAUSE_TRAP      = 6;
	localparam int CAUSE_ILL_OP    = 7;
	localparam int CAUSE_UNINIT_W  = 8;

	// value of the cause flags after power-on: brown-out and power-on set
	localparam logic [8:0] CAUSE_POR_VAL = 9'h003;

	// register byte offsets
	localparam logic [7:0] OFS_RESET_CONTROL_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_STATUS           = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK             = 8'h08;
	localparam logic [7:0] OFS_RETAINED             = 8'h0c;
	localparam logic [7:0] OFS_LIVE_STATUS          = 8'h10;

	// reset values of the designated registers
	localparam logic [8:0] IRQ_MASK_RST = 9'h000;

	// live status layout: requests in 8:1, master reset in 9
	localparam int LIVE_MASTER_BIT = 9;

	// AHB transfer type bit that marks NONSEQ or SEQ
	localparam int HTRANS_ACTIVE_BIT = 1;

	// the eight reset requests that arrive as synchronous levels
	typedef struct packed {
		logic uninit_wreg_reset;
		logic illegal_opcode_reset;
		logic trap_conflict_reset;
		logic config_mismatch_reset;
		logic watchdog_timeout_reset;
		logic software_reset_instruction;
		logic external_reset_pin;
		logic brown_out_reset;
	} reset_req_t;

	// AHB-Lite request side
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_t;

endpackage

// File: reset_release.sv
// two-stage release of the asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module reset_release
(
	// clock and raw reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// released copy
	output var  logic rstSyncN
);

	logic stage1;

	// assertion is immediate, release waits two edges
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1   <= 1'b0;
			rstSyncN <= 1'b0;
		end
		else
		begin
			stage1   <= 1'b1;
			rstSyncN <= stage1;
		end
	end

endmodule

`default_nettype wire

// File: cause_flag_cell.sv
// one reset cause flag: hardware set beats software write
`timescale 1ns/1ps
`default_nettype none

module cause_flag_cell
#(
	parameter logic POR_VAL = 1'b0
)
(
	// clock and power-on reset
	input  wire logic mclk,
	input  wire logic rstN,
	// hardware set and software write
	input  wire logic hwSet,
	input  wire logic wrEn,
	input  wire logic wrVal,
	// stored flag
	output var  logic flag
);

	// only power-on touches the flag; the master reset leaves it alone
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			flag <= POR_VAL;
		else if (hwSet)
			flag <= 1'b1;
		else if (wrEn)
			flag <= wrVal;
	end

endmodule

`default_nettype wire

// File: reset_req_model.sv
// reset request sources that stand beside the combiner
`timescale 1ns/1ps
`default_nettype none

module reset_req_model
	import reset_source_pkg::*;
(
	// clock
	input  wire logic                         mclk,
	// request levels
	output var  reset_source_pkg::reset_req_t resetReq
);
	initial resetReq = '0;

	task automatic drive(input logic [7:0] vec, input int cycles);
		@(posedge mclk);
		resetReq <= vec;
		repeat (cycles) @(posedge mclk);
		resetReq <= '0;
	endtask
endmodule

`default_nettype wire

// File: reset_source_combiner_tb.sv
// self-checking bench for the reset source combiner
`timescale 1ns/1ps
`default_nettype none

module reset_source_combiner_tb;
	import reset_source_pkg::*;

	typedef struct packed {logic [7:0] req; logic [8:0] cause;} row_t;
	// one row per request, the last raises all of them together
	row_t rows [9] = '{'{8'h01, 9'h002}, '{8'h02, 9'h004}, '{8'h04, 9'h008},
		'{8'h08, 9'h010}, '{8'h10, 9'h020}, '{8'h20, 9'h040}, '{8'h40, 9'h080},
		'{8'h80, 9'h100}, '{8'hff, 9'h1fe}};

	logic        mclk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        master_reset;
	logic [8:0]  resetCause;
	logic        irq;
	reset_req_t  resetReq;
	ahb_req_t    ahbIn;
	int          error_cnt = 0;
	int          compares = 0;
	int          cycles = 0;

	// one slave, so its ready is the bus ready
	assign ahbIn = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout};

	reset_source_combiner u_reset_source_combiner (.mclk(mclk), .rst_n(rst_n),
		.resetReq(resetReq), .ahbIn(ahbIn), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .master_reset(master_reset), .resetCause(resetCause), .irq(irq));

	reset_req_model u_reset_req_model (.mclk(mclk), .resetReq(resetReq));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// the whole run needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// address phase held until ready, then data phase until ready again
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0, "response");
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp, msg);
	endtask

	task automatic pulse(input logic [7:0] vec);
		fork
			u_reset_req_model.drive(vec, 2);
			begin
				repeat (2) @(posedge mclk);
				#1;
				chk({31'h0, master_reset}, 32'h1, "master on");
			end
		join
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, master_reset}, 32'h0, "master off");
	endtask

	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk({23'h0, resetCause}, {23'h0, CAUSE_POR_VAL}, "por flags");
		rdc(OFS_RESET_CONTROL_STATUS, 32'h003, "por read");
		rdc(8'h20, 32'h0, "unmapped");
		wr(OFS_RETAINED, 32'h5a5ac3c3);
		$display("test power-on done");
		for (int i = 0; i < 9; i++)
		begin
			wr(OFS_RESET_CONTROL_STATUS, 32'h0);
			pulse(rows[i].req);
			chk({23'h0, resetCause}, {23'h0, rows[i].cause}, "flag");
			rdc(OFS_RESET_CONTROL_STATUS, {23'h0, rows[i].cause}, "flag read");
			$display("test row %0d done", i);
		end
		fork
			u_reset_req_model.drive(8'h10, 4);
			begin
				@(posedge mclk);
				rdc(OFS_LIVE_STATUS, 32'h220, "live status");
			end
		join
		// flag write lands in the last cycle of a request: the set wins
		fork
			u_reset_req_model.drive(8'h40, 2);
			wr(OFS_RESET_CONTROL_STATUS, 32'h0);
		join
		repeat (2) @(posedge mclk);
		#1;
		chk({23'h0, resetCause}, 32'h080, "set beats write");
		$display("test live and set-wins done");
		rdc(OFS_RETAINED, 32'h5a5ac3c3, "retained");
		wr(OFS_IRQ_MASK, 32'h1ff);
		pulse(8'h08);
		rdc(OFS_IRQ_MASK, 32'h0, "mask reset");
		wr(OFS_IRQ_MASK, 32'h010);
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, irq}, 32'h1, "irq raised");
		wr(OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(OFS_IRQ_MASK, 32'h010);
		wr(OFS_IRQ_STATUS, 32'h010);
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rdc(OFS_IRQ_STATUS, 32'h1ee, "status cleared");
		$display("test interrupt done");
		wr(OFS_RESET_CONTROL_STATUS, 32'h1fc);
		repeat (2) @(posedge mclk);
		#1;
		chk({23'h0, resetCause}, 32'h1fc, "soft set");
		chk({31'h0, master_reset}, 32'h0, "no soft reset");
		$display("test soft flags done");
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk({23'h0, resetCause}, {23'h0, CAUSE_POR_VAL}, "second por");
		chk({31'h0, master_reset}, 32'h1, "por master");
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		rdc(OFS_RESET_CONTROL_STATUS, 32'h003, "second por read");
		$display("test second power-on done");
		give_verdict();
	end
endmodule

`default_nettype wire
